// [pkg/sbd_pkg.sv]
// Function
// - Shared 64-bit active-low data path, all agents
// - Driver asserts data valid each transfer
// - Four data transfers per bus clock
// - Capture on falling edges, alternating strobe pair
// - Strobe pair and flag per 16-bit group
// - Exactly four inversion flags, one per group
// - Receiver restores inverted group when flag active
// - Invert group when over half driven low
// - Flag active only when group is inverted
// - Driver holds bus busy while occupying bus; code releases busy one cycle before data valid and strobe N end when the last word takes the fourth slot
// - Nobody drives before bus busy released
// - Agent asserts ordering_a; processor only receives it
// - Addressed agent decides on ordering_a
// - Driver sends four parity bits with data
// - Driver may drop data valid for idles
package sbd_pkg;

  localparam int SBD_DATA_W        = 64;
  localparam int SBD_GRP_W         = 16;
  localparam int SBD_NGRP          = 4;
  localparam int SBD_FIFO_DEPTH    = 8;

  // Bit positions inside the shared pin vector
  localparam int SBD_P_D           = 0;
  localparam int SBD_P_DBI         = 64;
  localparam int SBD_P_DP          = 68;
  localparam int SBD_P_STBP        = 72;
  localparam int SBD_P_STBN        = 76;
  localparam int SBD_P_DATA_VALID_FLAG        = 80;
  localparam int SBD_P_DATA_BUS_IN_USE        = 81;
  localparam int SBD_P_ORDERING_A       = 82;
  localparam int SBD_PIN_W         = 83;

  // Timing
  localparam int SBD_CLK_PERIOD_NS  = 25;
  localparam int SBD_LINK_PERIOD_NS = 200;
  localparam int SBD_PHASES         = SBD_LINK_PERIOD_NS / SBD_CLK_PERIOD_NS;
  localparam int SBD_PH_W           = 3;
  localparam logic [SBD_PH_W-1:0] SBD_PH_LAST = SBD_PH_W'(SBD_PHASES - 1);

  // Idle level of every pin is high
  localparam logic [SBD_PIN_W-1:0] SBD_PIN_IDLE = {SBD_PIN_W{1'b1}};

endpackage

// [pkg/sbd_bus_if.sv]
`timescale 1ns/1ps
// Open-drain style resolution: a pin is low if any enabled driver pulls it low
interface sbd_bus_if (
  input logic bclk
);
  import sbd_pkg::*;

  logic [SBD_PIN_W-1:0] cpu_o;
  logic [SBD_PIN_W-1:0] cpu_oe_n;
  logic [SBD_PIN_W-1:0] agt_o;
  logic [SBD_PIN_W-1:0] agt_oe_n;
  logic [SBD_PIN_W-1:0] bus;

  assign bus = (cpu_oe_n | cpu_o) & (agt_oe_n | agt_o);

  modport cpu (
    input  bclk,
    input  bus,
    output cpu_o,
    output cpu_oe_n
  );

  modport agt (
    input  bclk,
    input  bus,
    output agt_o,
    output agt_oe_n
  );

endinterface

// [hdl/sbd_cpu_end.sv]
`timescale 1ns/1ps

module sbd_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_srst,
  // Fill side
  input  wire logic             i_valid,
  output logic                  o_ready,
  input  wire logic [WIDTH-1:0] i_data,
  // Drain side
  output logic                  o_valid,
  input  wire logic             i_ready,
  output logic      [WIDTH-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_r;
  logic [AW-1:0]    rd_r;
  logic [AW:0]      cnt_r;
  logic             push;
  logic             pop;

  assign o_ready = (cnt_r != (AW+1)'(DEPTH));
  assign o_valid = (cnt_r != '0);
  assign o_data  = mem_r[rd_r];
  assign push    = i_valid & o_ready;
  assign pop     = o_valid & i_ready;

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_r[wr_r] <= i_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      if (push) begin
        wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cnt_r <= '0;
    end else if (push && !pop) begin
      cnt_r <= cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

endmodule

// Data-phase engine shared by both ends: drives and receives the quad-pumped bus
module sbd_engine
  import sbd_pkg::*;
#(
  parameter logic SLOT       = 1'b0,
  parameter int   FIFO_DEPTH = SBD_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_srst,
  // Link pins
  input  wire logic                  i_bclk,
  input  wire logic [SBD_PIN_W-1:0]  i_bus,
  output logic      [SBD_PIN_W-1:0]  o_pin,
  output logic      [SBD_PIN_W-1:0]  o_oe_n,
  // Transmit stream
  input  wire logic                  i_tx_valid,
  output logic                       o_tx_ready,
  input  wire logic [SBD_DATA_W-1:0] i_tx_data,
  // Receive stream
  output logic                       o_rx_valid,
  output logic      [SBD_DATA_W-1:0] o_rx_data,
  output logic                       o_rx_perr,
  // Status
  output logic                       o_bus_owned,
  output logic                       o_ordering_a
);
  logic [SBD_PIN_W-1:0]  bus_s1_r;
  logic [SBD_PIN_W-1:0]  bus_s2_r;
  logic [SBD_PIN_W-1:0]  bus_s3_r;
  logic [2:0]            bclk_r;
  logic                  bclk_rise;
  logic [SBD_PH_W-1:0]   phase_r;
  logic                  par_r;
  logic                  own_r;
  logic                  own_nxt;
  logic                  f_valid;
  logic                  f_ready;
  logic [SBD_DATA_W-1:0] f_data;
  logic                  pop;
  logic [SBD_DATA_W-1:0] enc_d;
  logic [SBD_NGRP-1:0]   enc_inv;
  logic [SBD_NGRP-1:0]   enc_par;
  logic [SBD_DATA_W-1:0] d_o_r;
  logic [SBD_NGRP-1:0]   dbi_o_r;
  logic [SBD_NGRP-1:0]   dp_o_r;
  logic                  data_valid_flag_o_r;
  logic                  stbp_r;
  logic                  stbn_r;
  logic                  drv_en;
  logic [2:0]            self_r;
  logic [SBD_DATA_W-1:0] rx_d;
  logic [SBD_NGRP-1:0]   rx_perr;
  logic                  rx_trig;

  sbd_fifo #(
    .WIDTH (SBD_DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk   (i_clk),
    .i_srst  (i_srst),
    .i_valid (i_tx_valid),
    .o_ready (o_tx_ready),
    .i_data  (i_tx_data),
    .o_valid (f_valid),
    .i_ready (f_ready),
    .o_data  (f_data)
  );

  // Every pin and the link clock come from outside this clock domain
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      bus_s1_r <= SBD_PIN_IDLE;
      bus_s2_r <= SBD_PIN_IDLE;
      bus_s3_r <= SBD_PIN_IDLE;
      bclk_r   <= '0;
    end else begin
      bus_s1_r <= i_bus;
      bus_s2_r <= bus_s1_r;
      bus_s3_r <= bus_s2_r;
      bclk_r   <= {bclk_r[1:0], i_bclk};
    end
  end

  assign bclk_rise = bclk_r[1] & ~bclk_r[2];

  // Phase splits one bus clock into four two-cycle transfer slots
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      phase_r <= SBD_PH_LAST;
      par_r   <= 1'b0;
    end else if (bclk_rise) begin
      phase_r <= '0;
      par_r   <= ~par_r;
    end else if (phase_r != SBD_PH_LAST) begin
      phase_r <= phase_r + 1'b1;
    end
  end

  // Ownership changes only at a bus clock edge; the slot parity keeps
  // the two ends from seizing the same released bus together
  always_comb begin
    own_nxt = own_r;
    if (own_r) begin
      own_nxt = f_valid;
    end else if (f_valid && bus_s2_r[SBD_P_DATA_BUS_IN_USE] && (par_r == SLOT)) begin
      own_nxt = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      own_r <= 1'b0;
    end else if (bclk_rise) begin
      own_r <= own_nxt;
    end
  end

  // An empty FIFO in an even slot leaves data valid off for that slot
  assign f_ready = own_r & ~phase_r[0] & ~bclk_rise;
  assign pop     = f_valid & f_ready;

  for (genvar g = 0; g < SBD_NGRP; g++) begin : g_enc
    logic [SBD_GRP_W-1:0] grp;
    assign grp        = f_data[g*SBD_GRP_W +: SBD_GRP_W];
    // A logical one is an electrical low
    assign enc_inv[g] = ($countones(grp) > SBD_GRP_W / 2);
    assign enc_d[g*SBD_GRP_W +: SBD_GRP_W] = enc_inv[g] ? grp : ~grp;
    assign enc_par[g] = ^grp;
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      d_o_r    <= '1;
      dbi_o_r  <= '0;
      dp_o_r   <= '0;
      data_valid_flag_o_r <= 1'b0;
    end else if (!own_r) begin
      data_valid_flag_o_r <= 1'b0;
    end else if (f_ready) begin
      data_valid_flag_o_r <= pop;
      if (pop) begin
        d_o_r   <= enc_d;
        dbi_o_r <= enc_inv;
        dp_o_r  <= enc_par;
      end
    end
  end

  // Strobe falls in the second cycle of each slot, P then N alternately
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      stbp_r <= 1'b0;
      stbn_r <= 1'b0;
    end else begin
      stbp_r <= data_valid_flag_o_r & phase_r[0] & ~phase_r[1];
      stbn_r <= data_valid_flag_o_r & phase_r[0] & phase_r[1];
    end
  end

  assign drv_en = own_r | data_valid_flag_o_r | stbp_r | stbn_r;

  always_comb begin
    o_pin  = SBD_PIN_IDLE;
    o_oe_n = SBD_PIN_IDLE;
    o_pin[SBD_P_D +: SBD_DATA_W]  = d_o_r;
    o_pin[SBD_P_DBI +: SBD_NGRP]  = ~dbi_o_r;
    o_pin[SBD_P_DP +: SBD_NGRP]   = ~dp_o_r;
    o_pin[SBD_P_STBP +: SBD_NGRP] = {SBD_NGRP{~stbp_r}};
    o_pin[SBD_P_STBN +: SBD_NGRP] = {SBD_NGRP{~stbn_r}};
    o_pin[SBD_P_DATA_VALID_FLAG]             = ~data_valid_flag_o_r;
    o_oe_n[SBD_P_D +: 80]         = {80{~drv_en}};
    o_oe_n[SBD_P_DATA_VALID_FLAG]            = ~drv_en;
    // Busy is only ever pulled low, never driven high
    o_pin[SBD_P_DATA_BUS_IN_USE]             = ~own_r;
    o_oe_n[SBD_P_DATA_BUS_IN_USE]            = ~own_r;
  end

  // Own transfers echo back through the synchroniser; mask them out
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      self_r <= '0;
    end else begin
      self_r <= {self_r[1:0], drv_en};
    end
  end

  for (genvar g = 0; g < SBD_NGRP; g++) begin : g_dec
    logic [SBD_GRP_W-1:0] raw;
    logic [SBD_GRP_W-1:0] val;
    assign raw        = bus_s2_r[SBD_P_D + g*SBD_GRP_W +: SBD_GRP_W];
    assign val        = bus_s2_r[SBD_P_DBI + g] ? ~raw : raw;
    assign rx_d[g*SBD_GRP_W +: SBD_GRP_W] = val;
    assign rx_perr[g] = (^val) != ~bus_s2_r[SBD_P_DP + g];
  end

  // Groups are strobed together by the driver, so group 0 paces the word
  assign rx_trig = ((~bus_s2_r[SBD_P_STBP] & bus_s3_r[SBD_P_STBP]) |
                    (~bus_s2_r[SBD_P_STBN] & bus_s3_r[SBD_P_STBN])) &
                   ~bus_s2_r[SBD_P_DATA_VALID_FLAG] & ~drv_en & ~(|self_r);

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_rx_valid <= 1'b0;
      o_rx_data  <= '0;
      o_rx_perr  <= 1'b0;
    end else begin
      o_rx_valid <= rx_trig;
      if (rx_trig) begin
        o_rx_data <= rx_d;
        o_rx_perr <= |rx_perr;
      end
    end
  end

  assign o_bus_owned = own_r;
  assign o_ordering_a     = ~bus_s2_r[SBD_P_ORDERING_A];

endmodule

// Processor end: never drives the ordering_a pin, only observes it
module sbd_cpu_end
  import sbd_pkg::*;
#(
  parameter int FIFO_DEPTH = SBD_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_srst,
  // Bus side
  sbd_bus_if.cpu                     bus_if,
  // Transmit stream
  input  wire logic                  i_tx_valid,
  output logic                       o_tx_ready,
  input  wire logic [SBD_DATA_W-1:0] i_tx_data,
  // Receive stream
  output logic                       o_rx_valid,
  output logic      [SBD_DATA_W-1:0] o_rx_data,
  output logic                       o_rx_perr,
  // Status
  output logic                       o_bus_owned,
  output logic                       o_ordering_a
);
  sbd_engine #(
    .SLOT       (1'b0),
    .FIFO_DEPTH (FIFO_DEPTH)
  ) u_eng (
    .i_clk       (i_clk),
    .i_srst      (i_srst),
    .i_bclk      (bus_if.bclk),
    .i_bus       (bus_if.bus),
    .o_pin       (bus_if.cpu_o),
    .o_oe_n      (bus_if.cpu_oe_n),
    .i_tx_valid  (i_tx_valid),
    .o_tx_ready  (o_tx_ready),
    .i_tx_data   (i_tx_data),
    .o_rx_valid  (o_rx_valid),
    .o_rx_data   (o_rx_data),
    .o_rx_perr   (o_rx_perr),
    .o_bus_owned (o_bus_owned),
    .o_ordering_a     (o_ordering_a)
  );

endmodule

// [hdl/sbd_agent_end.sv]
`timescale 1ns/1ps

// Chipset-side agent: same data phase, plus it owns the ordering_a pin
module sbd_agent_end
  import sbd_pkg::*;
#(
  parameter int FIFO_DEPTH = SBD_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_srst,
  // Bus side
  sbd_bus_if.agt                     bus_if,
  // Transmit stream
  input  wire logic                  i_tx_valid,
  output logic                       o_tx_ready,
  input  wire logic [SBD_DATA_W-1:0] i_tx_data,
  // Receive stream
  output logic                       o_rx_valid,
  output logic      [SBD_DATA_W-1:0] o_rx_data,
  output logic                       o_rx_perr,
  // Ordering and status
  input  wire logic                  i_ordering_a,
  output logic                       o_bus_owned
);
  logic [SBD_PIN_W-1:0] eng_pin;
  logic [SBD_PIN_W-1:0] eng_oe_n;
  logic                 ordering_a_r;

  sbd_engine #(
    .SLOT       (1'b1),
    .FIFO_DEPTH (FIFO_DEPTH)
  ) u_eng (
    .i_clk       (i_clk),
    .i_srst      (i_srst),
    .i_bclk      (bus_if.bclk),
    .i_bus       (bus_if.bus),
    .o_pin       (eng_pin),
    .o_oe_n      (eng_oe_n),
    .i_tx_valid  (i_tx_valid),
    .o_tx_ready  (o_tx_ready),
    .i_tx_data   (i_tx_data),
    .o_rx_valid  (o_rx_valid),
    .o_rx_data   (o_rx_data),
    .o_rx_perr   (o_rx_perr),
    .o_bus_owned (o_bus_owned),
    .o_ordering_a     ()
  );

  // As the addressed agent this end decides when ordering is not guaranteed
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ordering_a_r <= 1'b0;
    end else begin
      ordering_a_r <= i_ordering_a;
    end
  end

  always_comb begin
    bus_if.agt_o                = eng_pin;
    bus_if.agt_oe_n             = eng_oe_n;
    bus_if.agt_o[SBD_P_ORDERING_A]    = ~ordering_a_r;
    bus_if.agt_oe_n[SBD_P_ORDERING_A] = ~ordering_a_r;
  end

endmodule

// [bench/sbd_phase_asserts.sv]
`timescale 1ns/1ps
module sbd_phase_asserts
  import sbd_pkg::*;
(
  // Clock and reset
  input wire logic                 i_clk,
  input wire logic                 i_srst,
  // Link signals
  input wire logic                 bclk,
  input wire logic [SBD_PIN_W-1:0] cpu_o,
  input wire logic [SBD_PIN_W-1:0] cpu_oe_n,
  input wire logic [SBD_PIN_W-1:0] agt_o,
  input wire logic [SBD_PIN_W-1:0] agt_oe_n,
  input wire logic [SBD_PIN_W-1:0] bus
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  // A group may never show more than 8 low pins, and a set flag needs a true majority
  function automatic bit inv_ok(logic [SBD_PIN_W-1:0] b);
    inv_ok = 1'b1;
    for (int g = 0; g < SBD_NGRP; g++) begin
      if ($countones(b[g*SBD_GRP_W +: SBD_GRP_W]) < (b[SBD_P_DBI+g] ? 8 : 9)) inv_ok = 1'b0;
    end
  endfunction

  // Even group width: parity of the pins equals parity of the true data either way
  function automatic bit par_ok(logic [SBD_PIN_W-1:0] b);
    par_ok = 1'b1;
    for (int g = 0; g < SBD_NGRP; g++) begin
      if (b[SBD_P_DP+g] == ^b[g*SBD_GRP_W +: SBD_GRP_W]) par_ok = 1'b0;
    end
  endfunction

  reset_idle_a: assert property ($fell(i_srst) |-> bus == SBD_PIN_IDLE)
    else $error("pins not idle after reset");
  one_driver_a: assert property (((~cpu_oe_n[SBD_DATA_W-1:0]) & (~agt_oe_n[SBD_DATA_W-1:0])) == '0)
    else $error("both ends drive data");
  cpu_no_ordering_a_a: assert property (cpu_oe_n[SBD_P_ORDERING_A])
    else $error("processor end drives ordering_a");
  grab_valid_a: assert property ($fell(bus[SBD_P_DATA_BUS_IN_USE]) |-> ##[1:3] !bus[SBD_P_DATA_VALID_FLAG])
    else $error("no valid data after busy taken");
  valid_busy_a: assert property (!bus[SBD_P_DATA_VALID_FLAG] |->
    !bus[SBD_P_DATA_BUS_IN_USE] || !$past(bus[SBD_P_DATA_BUS_IN_USE]) || !$past(bus[SBD_P_DATA_BUS_IN_USE], 2))
    else $error("valid data without busy");
  strobe_valid_a: assert property ($fell(bus[SBD_P_STBP]) || $fell(bus[SBD_P_STBN]) |-> !bus[SBD_P_DATA_VALID_FLAG])
    else $error("strobe without valid data");
  strobe_pulse_a: assert property (!bus[SBD_P_STBP] || !bus[SBD_P_STBN] |=>
    bus[SBD_P_STBP] && bus[SBD_P_STBN])
    else $error("strobe longer than one cycle");
  strobe_groups_a: assert property (bus[SBD_P_STBP +: 4] == {4{bus[SBD_P_STBP]}}
    && bus[SBD_P_STBN +: 4] == {4{bus[SBD_P_STBN]}})
    else $error("group strobes differ");
  inversion_a: assert property (!bus[SBD_P_DATA_VALID_FLAG] |-> inv_ok(bus))
    else $error("inversion flag wrong");
  parity_a: assert property (!bus[SBD_P_DATA_VALID_FLAG] |-> par_ok(bus))
    else $error("parity wrong");
  busy_pull_a: assert property ((cpu_oe_n[SBD_P_DATA_BUS_IN_USE] || !cpu_o[SBD_P_DATA_BUS_IN_USE]) &&
    (agt_oe_n[SBD_P_DATA_BUS_IN_USE] || !agt_o[SBD_P_DATA_BUS_IN_USE]))
    else $error("busy driven high");
endmodule

// [bench/system_bus_data_phase_tb.sv]
`timescale 1ns/1ps
module system_bus_data_phase_tb;
  import sbd_pkg::*;
  typedef struct packed {
    logic [SBD_DATA_W-1:0] din;
    logic                  perr;
  } sbd_row_t;
  typedef logic [SBD_DATA_W:0] sbd_word_t;

  logic                  i_clk = 1'b0;
  logic                  i_srst = 1'b1;
  logic                  bclk = 1'b0;
  logic                  tx_valid [2];
  logic [SBD_DATA_W-1:0] tx_data [2];
  logic                  tx_ready [2];
  logic                  rx_valid [2];
  logic [SBD_DATA_W-1:0] rx_data [2];
  logic                  rx_perr [2];
  logic                  owned [2];
  logic                  cpu_ordering_a;
  logic                  agt_ordering_a = 1'b0;
  sbd_word_t             rxq [2][$];
  sbd_word_t             expq [2][$];
  int                    fail_count = 0;
  int                    samples_checked = 0;
  int                    stalls = 0;
  // Group counts of 7, 8 and 9 ones sit on both sides of the inversion threshold
  sbd_row_t              rows [8] = '{
    '{64'h0000_0000_0000_0000, 1'b0}, '{64'hffff_ffff_ffff_ffff, 1'b0},
    '{64'h00ff_01ff_fe00_ff01, 1'b0}, '{64'h5555_aaaa_8000_0001, 1'b0},
    '{64'h0123_4567_89ab_cdef, 1'b0}, '{64'hfedc_ba98_7654_3210, 1'b0},
    '{64'h7fff_0001_fffe_8000, 1'b0}, '{64'h1111_eeee_0f0f_f0f0, 1'b0}};

  always #12.5 i_clk = ~i_clk;
  initial begin
    #37;
    forever #100 bclk = ~bclk;
  end

  sbd_bus_if bus_if (.bclk(bclk));
  sbd_cpu_end i_sbd_cpu_end (.i_clk(i_clk), .i_srst(i_srst), .bus_if(bus_if.cpu),
    .i_tx_valid(tx_valid[0]), .o_tx_ready(tx_ready[0]), .i_tx_data(tx_data[0]), .o_rx_valid(rx_valid[0]),
    .o_rx_data(rx_data[0]), .o_rx_perr(rx_perr[0]), .o_bus_owned(owned[0]), .o_ordering_a(cpu_ordering_a));
  sbd_agent_end i_sbd_agent_end (.i_clk(i_clk), .i_srst(i_srst), .bus_if(bus_if.agt),
    .i_tx_valid(tx_valid[1]), .o_tx_ready(tx_ready[1]), .i_tx_data(tx_data[1]), .o_rx_valid(rx_valid[1]),
    .o_rx_data(rx_data[1]), .o_rx_perr(rx_perr[1]), .i_ordering_a(agt_ordering_a), .o_bus_owned(owned[1]));
  sbd_phase_asserts i_chk (.i_clk(i_clk), .i_srst(i_srst), .bclk(bclk), .cpu_o(bus_if.cpu_o),
    .cpu_oe_n(bus_if.cpu_oe_n), .agt_o(bus_if.agt_o), .agt_oe_n(bus_if.agt_oe_n), .bus(bus_if.bus));

  // Pulses launch on the rising edge; the falling edge sees them settled
  always @(negedge i_clk) begin
    for (int e = 0; e < 2; e++) begin
      if (rx_valid[e] === 1'b1) rxq[e].push_back({rx_perr[e], rx_data[e]});
    end
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input sbd_word_t seen, input sbd_word_t exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Called at a falling edge; ready is settled there and cannot change before the next rise.
  // Valid stays up into the next call, so the caller lowers it after the last word.
  task automatic send(input int e, input logic [SBD_DATA_W-1:0] w, input logic p);
    int k;
    tx_valid[e] = 1'b1;
    tx_data[e] = w;
    for (k = 0; k < 400 && tx_ready[e] !== 1'b1; k++) begin
      stalls++;
      @(negedge i_clk);
    end
    if (k == 400) begin
      fail_count++;
      tally_and_finish();
    end
    expq[1-e].push_back({p, w});
    @(negedge i_clk);
  endtask

  task automatic drain(input int e);
    int k;
    for (k = 0; k < 4000 && rxq[e].size() < expq[e].size(); k++) @(negedge i_clk);
    if (k == 4000) begin
      fail_count++;
      tally_and_finish();
    end
    while (expq[e].size() > 0) check("rx word", rxq[e].pop_front(), expq[e].pop_front());
    check("rx extra", (SBD_DATA_W+1)'(rxq[e].size()), '0);
  endtask

  initial begin
    int s;
    tx_valid = '{1'b0, 1'b0};
    tx_data = '{'0, '0};
    repeat (5) @(posedge i_clk);
    @(negedge i_clk);
    i_srst = 1'b0;
    check("reset state", (SBD_DATA_W+1)'({tx_ready[0], tx_ready[1], rx_valid[0], rx_valid[1],
      owned[0], owned[1], cpu_ordering_a}), (SBD_DATA_W+1)'(7'h60));
    for (int e = 0; e < 2; e++) begin
      for (int r = 0; r < 8; r++) send(e, rows[r].din, rows[r].perr);
      tx_valid[e] = 1'b0;
      drain(1 - e);
    end
    // Both ends loaded at once: the FIFOs must fill and refuse while one end holds the bus until its FIFO empties
    s = stalls;
    fork
      begin
        for (int k = 0; k < 12; k++) send(0, {rows[k % 8].din[31:0], 32'(k)}, 1'b0);
        tx_valid[0] = 1'b0;
      end
      begin
        for (int k = 0; k < 12; k++) send(1, {32'(k), rows[(k + 3) % 8].din[63:32]}, 1'b0);
        tx_valid[1] = 1'b0;
      end
    join
    check("fifo refused", (SBD_DATA_W+1)'(stalls > s), (SBD_DATA_W+1)'(1));
    drain(0);
    drain(1);
    repeat (20) @(negedge i_clk);
    check("busy released", (SBD_DATA_W+1)'({owned[0], owned[1]}), '0);
    check("bus idle", (SBD_DATA_W+1)'(bus_if.bus === SBD_PIN_IDLE), (SBD_DATA_W+1)'(1));
    agt_ordering_a = 1'b1;
    repeat (6) @(negedge i_clk);
    check("ordering_a pin", (SBD_DATA_W+1)'({bus_if.bus[SBD_P_ORDERING_A], cpu_ordering_a}), (SBD_DATA_W+1)'(1));
    agt_ordering_a = 1'b0;
    repeat (6) @(negedge i_clk);
    check("ordering_a clear", (SBD_DATA_W+1)'({bus_if.bus[SBD_P_ORDERING_A], cpu_ordering_a}), (SBD_DATA_W+1)'(2));
    tally_and_finish();
  end
endmodule
